// [core/ssp_cfg.svh]
// bit positions, mode codes and reset values of the synchronous serial port
// assumes an 8-bit software view of every control and status byte
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH

// port_control_one fields
`define SSP_CTL_OV_BIT     6
`define SSP_CTL_EN_BIT     5
`define SSP_CTL_MODE_MSB   3
`define SSP_CTL_MODE_LSB   0
`define SSP_CTL_RESET      8'h00

// mode field codes
`define SSP_MODE_MASTER    4'h8
`define SSP_MODE_SLV7      4'h6
`define SSP_MODE_SLV10     4'h7
`define SSP_MODE_SLV7_SP   4'he
`define SSP_MODE_SLV10_SP  4'hf
`define SSP_MODE_FW_MASTER 4'hb

// port_status_register fields
`define SSP_ST_BF_BIT      0
`define SSP_ST_UA_BIT      1
`define SSP_ST_RW_BIT      2
`define SSP_ST_START_BIT   3
`define SSP_ST_STOP_BIT    4
`define SSP_ST_DA_BIT      5

// peripheral_interrupt_register flag position
`define SSP_PIR_FLAG_BIT   3

// pin_direction_register bits of the two bus pins
`define SSP_DIR_SCL_BIT    3
`define SSP_DIR_SDA_BIT    4

// address handling and byte bit counts
`define SSP_ADDR_RESET     8'h00
`define SSP_TEN_HEADER     5'h1e
`define SSP_BITS_PER_BYTE  4'h8
`define SSP_TX_LAST_BIT    4'h7

`endif

// [core/ssp_pkg.sv]
// types shared by the synchronous serial port modules
// assumes ssp_cfg.svh supplies the register constants; the state codes are set here
package ssp_pkg;

	typedef enum logic [2:0] {
		SSP_IDLE  = 3'b000,
		SSP_RECV  = 3'b001,
		SSP_ACK   = 3'b010,
		SSP_TXB   = 3'b011,
		SSP_TXACK = 3'b100
	} ssp_state_t;

	typedef struct packed {
		logic scl_m;
		logic scl_s;
		logic scl_d;
		logic sda_m;
		logic sda_s;
		logic sda_d;
	} ssp_sync_t;

	typedef struct packed {
		logic [8:0] cnt;
		logic       low;
	} ssp_baud_t;

	typedef struct packed {
		ssp_state_t st;
		logic [7:0] sr;
		logic [3:0] cnt;
		logic [7:0] ctl;
		logic [7:0] addr;
		logic [7:0] buf_q;
		logic [7:0] txsr;
		logic       bf;
		logic       ua;
		logic       ua_pend;
		logic       rw;
		logic       sbit;
		logic       pbit;
		logic       da;
		logic       pif;
		logic       ack_drv;
		logic       stretch;
		logic       is_addr;
		logic       tx;
		logic       ten_hi;
		logic       ten_ok;
		logic       mack;
	} ssp_core_t;

endpackage : ssp_pkg

// [core/ssp_pin_if.sv]
// bus-level events carried from the pin synchroniser to the slave engine
// assumes both ends share clk_sys
`timescale 1ns/1ps
`default_nettype none

interface ssp_pin_if;
	logic scl_s;
	logic sda_s;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;

	modport prod (output scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det);
	modport cons (input  scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det);
endinterface : ssp_pin_if

`default_nettype wire

// [core/ssp_pin_sync.sv]
// two-flop synchroniser for SCL and SDA with edge and start/stop detection
// assumes the bus pins are asynchronous to clk_sys and idle high
`timescale 1ns/1ps
`default_nettype none

module ssp_pin_sync
	import ssp_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic rst_n,
	input  wire logic scl_in,
	input  wire logic sda_in,
	ssp_pin_if.prod   pin
);

	ssp_sync_t q;
	ssp_sync_t n;

	always_comb begin
		n       = q;
		n.scl_m = scl_in;
		n.scl_s = q.scl_m;
		n.scl_d = q.scl_s;
		n.sda_m = sda_in;
		n.sda_s = q.sda_m;
		n.sda_d = q.sda_s;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			q <= '1;
		end else begin
			q <= n;
		end
	end

	// only the second flops and their delayed copies feed the detectors
	assign pin.scl_s     = q.scl_s;
	assign pin.sda_s     = q.sda_s;
	assign pin.scl_rise  = q.scl_s & ~q.scl_d;
	assign pin.scl_fall  = ~q.scl_s & q.scl_d;
	assign pin.start_det = q.scl_s & q.scl_d & q.sda_d & ~q.sda_s;
	assign pin.stop_det  = q.scl_s & q.scl_d & ~q.sda_d & q.sda_s;

endmodule : ssp_pin_sync

`default_nettype wire

// [core/ssp_baud.sv]
// master clock generator: one SCL period is 4 * (reload + 1) system clocks
// assumes clk_sys is the oscillator clock
`timescale 1ns/1ps
`default_nettype none

module ssp_baud
	import ssp_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic       run,
	input  wire logic [7:0] reload,
	output logic            scl_low
);

	ssp_baud_t  q;
	ssp_baud_t  n;
	logic [8:0] half_last;

	// each half period lasts 2 * (reload + 1) clocks
	assign half_last = {reload, 1'b1};

	always_comb begin
		n = q;
		if (!run) begin
			n.cnt = 9'h000;
			n.low = 1'b0;
		end else if (q.cnt == half_last) begin
			n.cnt = 9'h000;
			n.low = ~q.low;
		end else begin
			n.cnt = q.cnt + 9'h001;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign scl_low = q.low;

endmodule : ssp_baud

`default_nettype wire

// [core/ssp_slave.sv]
// synchronous serial port, I2C slave path with master clock generator
// assumes software strobes are one-cycle pulses on clk_sys and the bus
// has external pull-ups; pins are open drain (out fixed low, oe pulls)
`include "ssp_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module ssp_slave
	import ssp_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic       scl_in,
	output logic            scl_out,
	output logic            scl_oe,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	input  wire logic [7:0] pin_direction_register,
	input  wire logic       ctl_wr,
	input  wire logic [7:0] ctl_wdata,
	output logic [7:0]      port_control_one,
	input  wire logic       addr_wr,
	input  wire logic [7:0] addr_wdata,
	output logic [7:0]      address_reload_register,
	input  wire logic       buf_rd,
	input  wire logic       buf_wr,
	input  wire logic [7:0] buf_wdata,
	output logic [7:0]      receive_transmit_buffer,
	output logic [7:0]      port_status_register,
	input  wire logic       irq_clr,
	output logic            port_interrupt_flag,
	output logic [7:0]      peripheral_interrupt_register,
	input  wire logic       master_run
);

	ssp_core_t  q;
	ssp_core_t  n;
	ssp_pin_if  pin ();
	logic [3:0] mode;
	logic       en;
	logic       ov;
	logic       slave;
	logic       ten;
	logic       sp_mode;
	logic       master;
	logic       pins_ok;
	logic       m_low;

	// ------------------------------------------------------------------
	// pin sampling and master clock
	// ------------------------------------------------------------------
	ssp_pin_sync u_sync (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.scl_in  (scl_in),
		.sda_in  (sda_in),
		.pin     (pin)
	);

	ssp_baud u_baud (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.run     (master_run & master & pins_ok),
		.reload  (q.addr),
		.scl_low (m_low)
	);

	// ------------------------------------------------------------------
	// mode decode
	// ------------------------------------------------------------------
	assign mode    = q.ctl[`SSP_CTL_MODE_MSB:`SSP_CTL_MODE_LSB];
	assign en      = q.ctl[`SSP_CTL_EN_BIT];
	assign ov      = q.ctl[`SSP_CTL_OV_BIT];
	assign ten     = (mode == `SSP_MODE_SLV10) | (mode == `SSP_MODE_SLV10_SP);
	assign sp_mode = (mode == `SSP_MODE_SLV7_SP) | (mode == `SSP_MODE_SLV10_SP);
	assign slave   = ten | sp_mode | (mode == `SSP_MODE_SLV7);
	assign master  = (mode == `SSP_MODE_MASTER) | (mode == `SSP_MODE_FW_MASTER);
	// open drain only with both pins set as inputs
	assign pins_ok = en & (slave | master) & pin_direction_register[`SSP_DIR_SCL_BIT]
		& pin_direction_register[`SSP_DIR_SDA_BIT];

	// ------------------------------------------------------------------
	// slave engine
	// ------------------------------------------------------------------
	always_comb begin
		logic match;
		logic take;
		match = 1'b0;
		take  = 1'b0;
		n     = q;
		if (ctl_wr) begin
			n.ctl = ctl_wdata;
		end
		if (addr_wr) begin
			n.addr    = addr_wdata;
			n.ua      = 1'b0;
			n.stretch = 1'b0;
		end
		if (buf_wr) begin
			n.buf_q = buf_wdata;
		end
		if (buf_rd) begin
			n.bf = 1'b0;
		end
		if (irq_clr) begin
			n.pif = 1'b0;
		end
		if (!en || !slave) begin
			n.st      = SSP_IDLE;
			n.ack_drv = 1'b0;
			n.stretch = 1'b0;
			n.tx      = 1'b0;
			n.ten_hi  = 1'b0;
			n.ten_ok  = 1'b0;
		end else if (pin.start_det) begin
			n.st      = SSP_RECV;
			n.cnt     = 4'h0;
			n.is_addr = 1'b1;
			n.ack_drv = 1'b0;
			n.tx      = 1'b0;
			n.sbit    = 1'b1;
			n.pbit    = 1'b0;
			if (sp_mode) begin
				n.pif = 1'b1;
			end
		end else if (pin.stop_det) begin
			n.st      = SSP_IDLE;
			n.ack_drv = 1'b0;
			n.tx      = 1'b0;
			n.ten_hi  = 1'b0;
			n.ten_ok  = 1'b0;
			n.sbit    = 1'b0;
			n.pbit    = 1'b1;
			if (sp_mode) begin
				n.pif = 1'b1;
			end
		end else begin
			unique case (q.st)
				SSP_IDLE: begin
				end
				SSP_RECV: begin
					if (pin.scl_rise) begin
						n.sr  = {q.sr[6:0], pin.sda_s};
						n.cnt = q.cnt + 4'h1;
					end else if (pin.scl_fall && q.cnt == `SSP_BITS_PER_BYTE) begin
						if (!q.is_addr) begin
							match = 1'b1;
						end else if (!ten) begin
							match = (q.sr[7:1] == q.addr[7:1]);
							n.rw  = q.sr[0];
							n.tx  = q.sr[0];
						end else if (q.ten_hi && !q.ten_ok) begin
							match     = (q.sr == q.addr);
							n.ten_ok  = match;
							n.ua_pend = match;
						end else if (q.sr[7:3] == `SSP_TEN_HEADER && q.sr[2:1] == q.addr[2:1]) begin
							n.rw = q.sr[0];
							if (q.sr[0] && q.ten_ok) begin
								match = 1'b1;
								n.tx  = 1'b1;
							end else if (!q.sr[0]) begin
								// first byte must be a write
								match     = 1'b1;
								n.ten_hi  = 1'b1;
								n.ten_ok  = 1'b0;
								n.ua_pend = 1'b1;
							end
						end
						if (!match) begin
							n.st = SSP_IDLE;
						end else begin
							// full or overflow blocks ack and load
							take = ~q.bf & ~ov;
							if (!take && !q.is_addr) begin
								n.ctl[`SSP_CTL_OV_BIT] = 1'b1;
							end
							if (take) begin
								n.buf_q   = q.sr;
								n.bf      = 1'b1;
								n.ack_drv = 1'b1;
							end
							n.da = ~q.is_addr;
							n.st = SSP_ACK;
						end
					end
				end
				SSP_ACK: begin
					if (pin.scl_fall) begin
						n.pif     = 1'b1;
						n.ack_drv = 1'b0;
						n.cnt     = 4'h0;
						n.ua_pend = 1'b0;
						// hold SCL until the address is rewritten
						if (q.ua_pend) begin
							n.ua      = 1'b1;
							n.stretch = 1'b1;
						end
						if (q.tx && q.ack_drv) begin
							n.st   = SSP_TXB;
							n.txsr = q.buf_q;
						end else if (q.tx) begin
							n.st = SSP_IDLE;
						end else begin
							n.st      = SSP_RECV;
							n.is_addr = ten & ~q.ten_ok & q.ten_hi & ~q.ua_pend;
							if (q.ua_pend && !q.ten_ok) begin
								n.is_addr = 1'b1;
							end
						end
					end
				end
				SSP_TXB: begin
					if (pin.scl_fall) begin
						n.txsr = {q.txsr[6:0], 1'b1};
						n.cnt  = q.cnt + 4'h1;
						if (q.cnt == `SSP_TX_LAST_BIT) begin
							n.st   = SSP_TXACK;
							n.mack = 1'b0;
						end
					end
				end
				SSP_TXACK: begin
					if (pin.scl_rise) begin
						n.mack = ~pin.sda_s;
						if (pin.sda_s) begin
							n.st = SSP_IDLE;
							n.tx = 1'b0;
						end
					end else if (pin.scl_fall && q.mack) begin
						n.st   = SSP_TXB;
						n.txsr = q.buf_q;
						n.cnt  = 4'h0;
						n.pif  = 1'b1;
					end
				end
				default: begin
					n.st = SSP_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			q       <= '0;
			q.st    <= SSP_IDLE;
			q.ctl   <= `SSP_CTL_RESET;
			q.addr  <= `SSP_ADDR_RESET;
			q.txsr  <= 8'hff;
		end else begin
			q <= n;
		end
	end

	// ------------------------------------------------------------------
	// pins and software view
	// ------------------------------------------------------------------
	// open-drain drive
	assign sda_out = 1'b0;
	assign scl_out = 1'b0;
	assign sda_oe  = pins_ok & (q.ack_drv | (q.st == SSP_TXB & ~q.txsr[7]));
	assign scl_oe  = pins_ok & (q.stretch | m_low);

	assign port_control_one        = q.ctl;
	assign address_reload_register = q.addr;
	assign receive_transmit_buffer = q.buf_q;
	assign port_interrupt_flag     = q.pif;

	always_comb begin
		port_status_register                          = 8'h00;
		port_status_register[`SSP_ST_BF_BIT]          = q.bf;
		port_status_register[`SSP_ST_UA_BIT]          = q.ua;
		port_status_register[`SSP_ST_RW_BIT]          = q.rw;
		port_status_register[`SSP_ST_START_BIT]       = q.sbit;
		port_status_register[`SSP_ST_STOP_BIT]        = q.pbit;
		port_status_register[`SSP_ST_DA_BIT]          = q.da;
		peripheral_interrupt_register                 = 8'h00;
		peripheral_interrupt_register[`SSP_PIR_FLAG_BIT] = q.pif;
	end

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	property p_off_quiet;
		!en |-> !sda_oe && !scl_oe;
	endproperty
	a_off_quiet: assert property (p_off_quiet) else $error("pins driven while disabled");

	property p_ua_ten;
		$rose(q.ua) |-> $past(ten);
	endproperty
	a_ua_ten: assert property (p_ua_ten) else $error("update flag in seven-bit mode");

	property p_load;
		$rose(q.bf) |-> q.buf_q == $past(q.sr) && q.ack_drv;
	endproperty
	a_load: assert property (p_load) else $error("buffer full without load and ack");

	property p_block;
		q.st == SSP_RECV && pin.scl_fall && q.cnt == `SSP_BITS_PER_BYTE && (q.bf || ov) && en && slave
			&& !pin.start_det && !pin.stop_det |=> !q.ack_drv;
	endproperty
	a_block: assert property (p_block) else $error("ack given with full or overflow");

	property p_bf_clear;
		$fell(q.bf) |-> $past(buf_rd);
	endproperty
	a_bf_clear: assert property (p_bf_clear) else $error("buffer full cleared without read");

	property p_ov_clear;
		$fell(ov) |-> $past(ctl_wr);
	endproperty
	a_ov_clear: assert property (p_ov_clear) else $error("overflow cleared without write");

	property p_flag_ninth;
		q.st == SSP_ACK && pin.scl_fall && en && slave && !pin.start_det && !pin.stop_det |=> q.pif;
	endproperty
	a_flag_ninth: assert property (p_flag_ninth) else $error("flag missing on ninth fall");

	property p_stretch_rel;
		$fell(q.stretch) |-> $past(addr_wr) || !$past(en) || !$past(slave);
	endproperty
	a_stretch_rel: assert property (p_stretch_rel) else $error("SCL released without address write");

	property p_sp_irq;
		en && slave && sp_mode && pin.start_det |=> q.pif && q.sbit;
	endproperty
	a_sp_irq: assert property (p_sp_irq) else $error("start interrupt missing");

	property p_stop_idle;
		en && slave && pin.stop_det && !pin.start_det |=> q.st == SSP_IDLE ##1 !q.ack_drv;
	endproperty
	a_stop_idle: assert property (p_stop_idle) else $error("stop did not idle the slave");

endmodule : ssp_slave

`default_nettype wire

// [dv/ssp_i2c_master_model.sv]
// behavioural I2C bus master for the synchronous serial port bench
// assumes pull-ups on both lines in the bench and clk_sys as time base
`timescale 1ns/1ps
`default_nettype none

module ssp_i2c_master_model (
	input  wire logic clk_sys,
	input  wire logic scl,
	input  wire logic sda,
	output var logic  scl_low,
	output var logic  sda_low
);
	localparam int HALF = 16;

	initial begin
		scl_low = 1'h0;
		sda_low = 1'h0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : tick

	// release SCL and wait out a clock stretch, bounded
	task automatic scl_up();
		int k;
		k = 0;
		scl_low <= 1'h0;
		@(posedge clk_sys);
		while (scl !== 1'h1 && k < 4000) begin
			@(posedge clk_sys);
			k++;
		end
		tick(HALF);
	endtask : scl_up

	// data changes only while SCL is low
	task automatic one_bit(input logic b, output logic r);
		sda_low <= ~b;
		tick(4);
		scl_up();
		r = sda;
		scl_low <= 1'h1;
		tick(HALF);
	endtask : one_bit

	// also serves as repeated start
	task automatic start_cond();
		sda_low <= 1'h0;
		tick(4);
		scl_up();
		sda_low <= 1'h1;
		tick(HALF);
		scl_low <= 1'h1;
		tick(HALF);
	endtask : start_cond

	task automatic stop_cond();
		sda_low <= 1'h1;
		tick(4);
		scl_up();
		sda_low <= 1'h0;
		tick(HALF);
	endtask : stop_cond

	task automatic write_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) one_bit(d[i], r);
		one_bit(1'h1, r);
		ack = ~r;
	endtask : write_byte

	task automatic read_byte(input logic ack_m, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) one_bit(1'h1, d[i]);
		one_bit(~ack_m, r);
	endtask : read_byte
endmodule : ssp_i2c_master_model

`default_nettype wire

// [dv/tb_top.sv]
// self-checking bench for the synchronous serial port slave
// assumes the master model drives the bus and both lines have pull-ups
`include "ssp_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	logic       clk_sys, rst_n, ctl_wr, addr_wr, buf_rd, buf_wr, irq_clr, master_run;
	logic [7:0] dir, ctl_wdata, addr_wdata, buf_wdata, ctl, adr, rbuf, stat, pir, rd;
	logic       scl_out, scl_oe, sda_out, sda_oe, pif, m_scl_low, m_sda_low, ack;
	int         error_cnt, n_tests;
	wire        scl_bus = ~(m_scl_low | (scl_oe & ~scl_out));
	wire        sda_bus = ~(m_sda_low | (sda_oe & ~sda_out));

	ssp_slave i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .scl_in(scl_bus), .scl_out(scl_out), .scl_oe(scl_oe),
		.sda_in(sda_bus), .sda_out(sda_out), .sda_oe(sda_oe), .pin_direction_register(dir),
		.ctl_wr(ctl_wr), .ctl_wdata(ctl_wdata), .port_control_one(ctl), .addr_wr(addr_wr),
		.addr_wdata(addr_wdata), .address_reload_register(adr), .buf_rd(buf_rd), .buf_wr(buf_wr),
		.buf_wdata(buf_wdata), .receive_transmit_buffer(rbuf), .port_status_register(stat),
		.irq_clr(irq_clr), .port_interrupt_flag(pif), .peripheral_interrupt_register(pir),
		.master_run(master_run));

	ssp_i2c_master_model i_mst (.clk_sys(clk_sys), .scl(scl_bus), .sda(sda_bus), .scl_low(m_scl_low),
		.sda_low(m_sda_low));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED time=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask : chk

	function automatic logic [7:0] b8(input logic b);
		return {7'h00, b};
	endfunction : b8

	// strobe kinds: 0 control, 1 address, 2 buffer read, 3 buffer write, 4 flag clear
	task automatic sw(input int k, input logic [7:0] d);
		@(posedge clk_sys);
		ctl_wr <= (k == 0);
		addr_wr <= (k == 1);
		buf_rd <= (k == 2);
		buf_wr <= (k == 3);
		irq_clr <= (k == 4);
		ctl_wdata <= d;
		addr_wdata <= d;
		buf_wdata <= d;
		@(posedge clk_sys);
		{ctl_wr, addr_wr, buf_rd, buf_wr, irq_clr} <= 5'h00;
		@(negedge clk_sys);
	endtask : sw

	task automatic wb(input logic [7:0] d, input logic exp_ack);
		i_mst.write_byte(d, ack);
		@(negedge clk_sys);
		chk(b8(ack), b8(exp_ack));
	endtask : wb

	task automatic clean();
		sw(2, 8'h00);
		sw(4, 8'h00);
	endtask : clean

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_off();
		chk({stat | ctl}, 8'h00);
		chk({6'h00, pif, scl_oe | sda_oe}, 8'h00);
		chk({6'h00, scl_out, sda_out}, 8'h00);
		sw(1, 8'ha4);
		sw(0, {4'h0, `SSP_MODE_SLV7});
		i_mst.start_cond();
		wb(8'ha4, 1'h0);
		chk(b8(pif), 8'h00);
		i_mst.stop_cond();
		@(posedge clk_sys);
		dir <= 8'h08;
		sw(0, {4'h2, `SSP_MODE_SLV7});
		i_mst.start_cond();
		wb(8'ha4, 1'h0);
		i_mst.stop_cond();
		@(posedge clk_sys);
		dir <= 8'h18;
		clean();
	endtask : t_off

	task automatic t_write7();
		i_mst.start_cond();
		wb(8'ha4, 1'h1);
		chk(rbuf, 8'ha4);
		chk(stat & 8'h23, 8'h01);
		chk(pir, 8'h08);
		sw(2, 8'h00);
		chk(b8(stat[`SSP_ST_BF_BIT]), 8'h00);
		sw(4, 8'h00);
		wb(8'h3c, 1'h1);
		chk(rbuf, 8'h3c);
		chk(b8(stat[`SSP_ST_DA_BIT]), 8'h01);
		sw(4, 8'h00);
		wb(8'h55, 1'h0);
		chk(rbuf, 8'h3c);
		chk({6'h00, pif, ctl[`SSP_CTL_OV_BIT]}, 8'h03);
		clean();
		wb(8'h66, 1'h0);
		sw(0, 8'h26);
		chk(ctl, 8'h26);
		clean();
		wb(8'h77, 1'h1);
		chk(rbuf, 8'h77);
		clean();
		i_mst.stop_cond();
		i_mst.start_cond();
		wb(8'hb0, 1'h0);
		chk(b8(pif), 8'h00);
		i_mst.stop_cond();
	endtask : t_write7

	task automatic t_read7();
		i_mst.start_cond();
		wb(8'ha5, 1'h1);
		chk(b8(stat[`SSP_ST_RW_BIT]), 8'h01);
		sw(2, 8'h00);
		sw(3, 8'h96);
		sw(4, 8'h00);
		i_mst.read_byte(1'h1, rd);
		@(negedge clk_sys);
		chk(rd, 8'ha5);
		chk(b8(pif), 8'h01);
		i_mst.read_byte(1'h0, rd);
		chk(rd, 8'h96);
		i_mst.stop_cond();
		clean();
	endtask : t_read7

	task automatic t_modes();
		logic [3:0] md [5];
		logic       ex [5];
		md = '{`SSP_MODE_SLV7, `SSP_MODE_SLV10, `SSP_MODE_SLV7_SP, `SSP_MODE_SLV10_SP, `SSP_MODE_FW_MASTER};
		ex = '{1'h0, 1'h0, 1'h1, 1'h1, 1'h0};
		for (int i = 0; i < 5; i++) begin
			sw(0, {4'h2, md[i]});
			sw(4, 8'h00);
			i_mst.start_cond();
			i_mst.stop_cond();
			@(negedge clk_sys);
			chk(b8(pif), b8(ex[i]));
			chk(stat & 8'h18, 8'h10);
		end
	endtask : t_modes

	task automatic t_ten();
		sw(1, 8'hf2);
		sw(0, {4'h2, `SSP_MODE_SLV10});
		sw(4, 8'h00);
		i_mst.start_cond();
		wb(8'hf2, 1'h1);
		chk(stat & 8'h07, 8'h03);
		chk({6'h00, pif, scl_oe}, 8'h03);
		sw(1, 8'h5a);
		chk(adr, 8'h5a);
		chk({6'h00, stat[`SSP_ST_UA_BIT], scl_oe}, 8'h00);
		clean();
		wb(8'h5a, 1'h1);
		chk({6'h00, stat[`SSP_ST_UA_BIT], scl_oe}, 8'h03);
		sw(1, 8'hf2);
		clean();
		wb(8'h11, 1'h1);
		chk(rbuf, 8'h11);
		clean();
		i_mst.start_cond();
		wb(8'hf3, 1'h1);
		chk({6'h00, pif, stat[`SSP_ST_BF_BIT]}, 8'h03);
		sw(1, 8'hf2);
		clean();
		i_mst.read_byte(1'h0, rd);
		i_mst.stop_cond();
	endtask : t_ten

	task automatic wait_oe(input logic v, inout int n);
		while (scl_oe !== v && n < 1000) begin
			@(negedge clk_sys);
			n++;
		end
	endtask : wait_oe

	task automatic t_master();
		int n;
		sw(1, 8'h03);
		sw(0, {4'h2, `SSP_MODE_MASTER});
		@(posedge clk_sys);
		master_run <= 1'h1;
		n = 0;
		wait_oe(1'h1, n);
		wait_oe(1'h0, n);
		n = 0;
		wait_oe(1'h1, n);
		wait_oe(1'h0, n);
		// four times (reload plus one) clocks per SCL period
		chk(n[7:0], 8'h10);
		@(posedge clk_sys);
		master_run <= 1'h0;
	endtask : t_master

	// ----------------------------------------
	// run control
	// ----------------------------------------
	task automatic end_of_test();
		if (error_cnt == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_of_test

	initial begin
		clk_sys = 1'h0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	initial begin
		repeat (100000) @(posedge clk_sys);
		error_cnt++;
		end_of_test();
	end

	initial begin
		error_cnt = 0;
		n_tests = 0;
		rst_n = 1'h0;
		dir = 8'h18;
		{ctl_wr, addr_wr, buf_rd, buf_wr, irq_clr, master_run} = 6'h00;
		{ctl_wdata, addr_wdata, buf_wdata} = 24'h000000;
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'h1;
		@(negedge clk_sys);
		t_off();
		t_write7();
		t_read7();
		t_modes();
		t_ten();
		t_master();
		end_of_test();
	end
endmodule : tb_top

`default_nettype wire
